// file: rtl/csr_status_reader.sv
// card adapter status-query responder with register port and interrupt
// Function
// - selectors 0..63 return two words, last line then last column of that file.
// - the last line reported is held between 1 and that file's configured maximum.
// - selector 256 returns four words forming the 64-file presence map.
// - bit b of presence word w is set exactly when file 16*w+b exists.
// - selector 512 returns capacity, used and free in kB, each low word then high word.
// - a nonzero amount under one kilobyte is reported as 1.
// - selector 768 returns one word with the firmware version times one hundred.
// - selector 1024 returns flags: bit0 not mounted, bit1 card full, bit2 error recorded.
// - flag bit3 is an adapter hardware fault, bit4 a card fault, bits 5..15 read zero.
// - selector 1280 returns up to five most recent error code and detail pairs.
// - error records interleave code at even and detail at odd offsets over ten words.
// - the number of words sent matches the content: 2, 4, 6, 1, 1 or 10.
// - the card is available only while mounted; unmounted drives the not-mounted flag.
`timescale 1ns/1ns
`default_nettype none
`include "csr_consts.svh"

module csr_status_reader
  import csr_pkg::*;
#(
  parameter int FILES = 64,
  parameter logic [15:0] FW_VERSION = `CSR_FW_VERSION
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic [15:0] reqSelector,
  input wire logic [15:0] reqChannel,
  output logic wordValid,
  output logic [3:0] wordIndex,
  output logic [15:0] wordData,
  output logic reqDone,
  output logic reqInvalid,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  output logic irq
);

  csr_state_e state_q;
  csr_kind_e kind_q;
  logic [15:0] sel_q;
  logic [3:0] len_q;
  logic [3:0] idx_q;
  logic wordValid_q;
  logic [3:0] wordIndex_q;
  logic [15:0] wordData_q;
  logic done_q;
  logic invalid_q;
  logic [2:0] ctrl_q;
  logic [5:0] fileIdx_q;
  logic [15:0] lineMem [FILES];
  logic [15:0] colMem [FILES];
  logic [15:0] maxMem [FILES];
  logic [63:0] presence_q;
  logic [31:0] capBytes_q;
  logic [31:0] usedBytes_q;
  logic [31:0] freeBytes_q;
  logic [15:0] errCode [`CSR_ERR_DEPTH];
  logic [15:0] errDetail [`CSR_ERR_DEPTH];
  logic [2:0] errCnt_q;
  logic [2:0] irqStat_q;
  logic [2:0] irqEn_q;
  logic [31:0] rdData_q;
  logic mounted;
  logic cardFull;
  logic [15:0] errFlags;
  logic [2:0] irqEvents;
  logic start;
  csr_kind_e startKind;
  logic startBad;

  function automatic csr_kind_e kindOf(input logic [15:0] sel);
    if (sel <= `CSR_SEL_FILE_LAST) begin
      return CSR_K_FILE;
    end
    case (sel)
      `CSR_SEL_PRESENCE: return CSR_K_PRES;
      `CSR_SEL_SPACE: return CSR_K_SPACE;
      `CSR_SEL_VERSION: return CSR_K_VER;
      `CSR_SEL_ERR_FLAGS: return CSR_K_FLAGS;
      `CSR_SEL_ERR_LOG: return CSR_K_LOG;
      default: return CSR_K_NONE;
    endcase
  endfunction

  function automatic logic [3:0] lenOf(input csr_kind_e k);
    case (k)
      CSR_K_FILE: return `CSR_LEN_FILE;
      CSR_K_PRES: return `CSR_LEN_PRESENCE;
      CSR_K_SPACE: return `CSR_LEN_SPACE;
      CSR_K_VER: return `CSR_LEN_VERSION;
      CSR_K_FLAGS: return `CSR_LEN_ERR_FLAGS;
      CSR_K_LOG: return `CSR_LEN_ERR_LOG;
      default: return 4'h0;
    endcase
  endfunction

  // byte count to kB, a nonzero amount below 1 kB counts as 1
  function automatic logic [31:0] toKb(input logic [31:0] bytes);
    logic [31:0] kb;
    kb = bytes >> `CSR_KB_SHIFT;
    if (bytes != 32'h0000_0000 && kb == 32'h0000_0000) begin
      kb = 32'h0000_0001;
    end
    return kb;
  endfunction

  function automatic logic [15:0] lineOf(input logic [5:0] f);
    logic [15:0] ln;
    logic [15:0] mx;
    ln = lineMem[f];
    mx = maxMem[f];
    if (mx == 16'h0000) begin
      mx = 16'h0001;
    end
    if (ln == 16'h0000) begin
      ln = 16'h0001;
    end else if (ln > mx) begin
      ln = mx;
    end
    return ln;
  endfunction

  function automatic logic [15:0] wordFor(input csr_kind_e k, input logic [15:0] sel, input logic [3:0] i);
    logic [31:0] kb;
    logic [2:0] rec;
    kb = 32'h0000_0000;
    rec = i[3:1];
    case (k)
      CSR_K_FILE: begin
        return i[0] ? colMem[sel[5:0]] : lineOf(sel[5:0]);
      end
      CSR_K_PRES: begin
        return presence_q[{i[1:0], 4'h0} +: 16];
      end
      CSR_K_SPACE: begin
        case (i[2:1])
          2'd0: kb = toKb(capBytes_q);
          2'd1: kb = toKb(usedBytes_q);
          default: kb = toKb(freeBytes_q);
        endcase
        return i[0] ? kb[31:16] : kb[15:0];
      end
      CSR_K_VER: return FW_VERSION;
      CSR_K_FLAGS: return errFlags;
      CSR_K_LOG: begin
        if (rec >= errCnt_q) begin
          return 16'h0000;
        end
        return i[0] ? errDetail[rec] : errCode[rec];
      end
      default: return 16'h0000;
    endcase
  endfunction

  assign mounted = ctrl_q[`CSR_CTRL_MOUNTED];
  assign cardFull = mounted && (toKb(freeBytes_q) == 32'h0000_0000);
  assign errFlags = {11'h000, ctrl_q[`CSR_CTRL_CARD_FAULT], ctrl_q[`CSR_CTRL_HW_FAULT],
                     (errCnt_q != 3'd0), cardFull, !mounted};

  assign reqReady = (state_q == CSR_IDLE);
  assign start = reqValid && reqReady;
  assign startKind = kindOf(reqSelector);
  // a channel other than 1 or 2 is refused like an unknown selector
  assign startBad = (startKind == CSR_K_NONE) ||
                    (reqChannel != `CSR_CHAN_FIRST && reqChannel != `CSR_CHAN_SECOND);

  // request sequencer
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= CSR_IDLE;
      kind_q <= CSR_K_NONE;
      sel_q <= 16'h0000;
      len_q <= 4'h0;
      idx_q <= 4'h0;
    end else begin
      case (state_q)
        CSR_IDLE: begin
          if (start && !startBad) begin
            state_q <= CSR_SEND;
            kind_q <= startKind;
            sel_q <= reqSelector;
            len_q <= lenOf(startKind);
            idx_q <= 4'h0;
          end
        end
        CSR_SEND: begin
          idx_q <= idx_q + 4'h1;
          if (idx_q == len_q - 4'h1) begin
            state_q <= CSR_FINISH;
          end
        end
        CSR_FINISH: begin
          state_q <= CSR_IDLE;
        end
        default: begin
          state_q <= CSR_IDLE;
        end
      endcase
    end
  end

  // result words and completion
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wordValid_q <= 1'b0;
      wordIndex_q <= 4'h0;
      wordData_q <= 16'h0000;
      done_q <= 1'b0;
      invalid_q <= 1'b0;
    end else begin
      wordValid_q <= (state_q == CSR_SEND);
      if (state_q == CSR_SEND) begin
        wordIndex_q <= idx_q;
        wordData_q <= wordFor(kind_q, sel_q, idx_q);
      end
      done_q <= (state_q == CSR_FINISH);
      invalid_q <= start && startBad;
    end
  end

  assign wordValid = wordValid_q;
  assign wordIndex = wordIndex_q;
  assign wordData = wordData_q;
  assign reqDone = done_q;
  assign reqInvalid = invalid_q;

  // card state written by the adapter firmware
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_q <= `CSR_CTRL_RESET;
      fileIdx_q <= 6'h00;
      presence_q <= 64'h0000_0000_0000_0000;
      capBytes_q <= 32'h0000_0000;
      usedBytes_q <= 32'h0000_0000;
      freeBytes_q <= 32'h0000_0000;
    end else if (regWr) begin
      case (regAddr)
        `CSR_OFF_CTRL: ctrl_q <= regWrData[2:0];
        `CSR_OFF_FILE_IDX: fileIdx_q <= regWrData[5:0];
        `CSR_OFF_PRES_LO: presence_q[31:0] <= regWrData;
        `CSR_OFF_PRES_HI: presence_q[63:32] <= regWrData;
        `CSR_OFF_CAP: capBytes_q <= regWrData;
        `CSR_OFF_USED: usedBytes_q <= regWrData;
        `CSR_OFF_FREE: freeBytes_q <= regWrData;
        default: begin
        end
      endcase
    end
  end

  // per-file positions
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int f = 0; f < FILES; f++) begin
        lineMem[f] <= 16'h0000;
        colMem[f] <= 16'h0000;
        maxMem[f] <= 16'h0000;
      end
    end else if (regWr && regAddr == `CSR_OFF_FILE_POS) begin
      lineMem[fileIdx_q] <= regWrData[15:0];
      colMem[fileIdx_q] <= regWrData[31:16];
    end else if (regWr && regAddr == `CSR_OFF_FILE_MAX) begin
      maxMem[fileIdx_q] <= regWrData[15:0];
    end
  end

  // error log, newest record first, oldest dropped past five
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      errCnt_q <= 3'd0;
      for (int r = 0; r < `CSR_ERR_DEPTH; r++) begin
        errCode[r] <= 16'h0000;
        errDetail[r] <= 16'h0000;
      end
    end else if (regWr && regAddr == `CSR_OFF_ERR_CLR) begin
      errCnt_q <= 3'd0;
    end else if (regWr && regAddr == `CSR_OFF_ERR_PUSH) begin
      errCode[0] <= regWrData[15:0];
      errDetail[0] <= regWrData[31:16];
      for (int r = 1; r < `CSR_ERR_DEPTH; r++) begin
        errCode[r] <= errCode[r-1];
        errDetail[r] <= errDetail[r-1];
      end
      if (errCnt_q != 3'(`CSR_ERR_DEPTH)) begin
        errCnt_q <= errCnt_q + 3'd1;
      end
    end
  end

  assign irqEvents = {regWr && regAddr == `CSR_OFF_ERR_PUSH, invalid_q, done_q};

  // sticky interrupt status, a new event wins over a clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irqStat_q <= 3'h0;
      irqEn_q <= 3'h0;
    end else begin
      if (regWr && regAddr == `CSR_OFF_IRQ_EN) begin
        irqEn_q <= regWrData[2:0];
      end
      if (regWr && regAddr == `CSR_OFF_IRQ_CLR) begin
        irqStat_q <= (irqStat_q & ~regWrData[2:0]) | irqEvents;
      end else begin
        irqStat_q <= irqStat_q | irqEvents;
      end
    end
  end

  assign irq = |(irqStat_q & irqEn_q);

  // register read port, data one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdData_q <= 32'h0000_0000;
    end else if (regRd) begin
      case (regAddr)
        `CSR_OFF_CTRL: rdData_q <= {29'h0000_0000, ctrl_q};
        `CSR_OFF_FILE_IDX: rdData_q <= {26'h000_0000, fileIdx_q};
        `CSR_OFF_FILE_POS: rdData_q <= {colMem[fileIdx_q], lineMem[fileIdx_q]};
        `CSR_OFF_FILE_MAX: rdData_q <= {16'h0000, maxMem[fileIdx_q]};
        `CSR_OFF_PRES_LO: rdData_q <= presence_q[31:0];
        `CSR_OFF_PRES_HI: rdData_q <= presence_q[63:32];
        `CSR_OFF_CAP: rdData_q <= capBytes_q;
        `CSR_OFF_USED: rdData_q <= usedBytes_q;
        `CSR_OFF_FREE: rdData_q <= freeBytes_q;
        `CSR_OFF_ERR_CNT: rdData_q <= {29'h0000_0000, errCnt_q};
        `CSR_OFF_IRQ_STAT: rdData_q <= {29'h0000_0000, irqStat_q};
        `CSR_OFF_IRQ_EN: rdData_q <= {29'h0000_0000, irqEn_q};
        `CSR_OFF_STATUS: rdData_q <= {15'h0000, reqReady, errFlags};
        default: rdData_q <= 32'h0000_0000;
      endcase
    end else begin
      rdData_q <= 32'h0000_0000;
    end
  end

  assign regRdData = rdData_q;

endmodule

`default_nettype wire

// file: pkg/csr_consts.svh
// register offsets, field positions, reset values and selector codes
`ifndef CSR_CONSTS_SVH
`define CSR_CONSTS_SVH
`define CSR_OFF_CTRL 8'h00
`define CSR_OFF_FILE_IDX 8'h04
`define CSR_OFF_FILE_POS 8'h08
`define CSR_OFF_FILE_MAX 8'h0C
`define CSR_OFF_PRES_LO 8'h10
`define CSR_OFF_PRES_HI 8'h14
`define CSR_OFF_CAP 8'h18
`define CSR_OFF_USED 8'h1C
`define CSR_OFF_FREE 8'h20
`define CSR_OFF_ERR_PUSH 8'h24
`define CSR_OFF_ERR_CLR 8'h28
`define CSR_OFF_ERR_CNT 8'h2C
`define CSR_OFF_IRQ_STAT 8'h30
`define CSR_OFF_IRQ_EN 8'h34
`define CSR_OFF_IRQ_CLR 8'h38
`define CSR_OFF_STATUS 8'h3C
`define CSR_CTRL_MOUNTED 0
`define CSR_CTRL_HW_FAULT 1
`define CSR_CTRL_CARD_FAULT 2
`define CSR_IRQ_DONE 0
`define CSR_IRQ_INVALID 1
`define CSR_IRQ_ERROR 2
`define CSR_CTRL_RESET 3'h0
`define CSR_SEL_FILE_LAST 16'h003F
`define CSR_SEL_PRESENCE 16'h0100
`define CSR_SEL_SPACE 16'h0200
`define CSR_SEL_VERSION 16'h0300
`define CSR_SEL_ERR_FLAGS 16'h0400
`define CSR_SEL_ERR_LOG 16'h0500
`define CSR_CHAN_FIRST 16'h0001
`define CSR_CHAN_SECOND 16'h0002
`define CSR_LEN_FILE 4'h2
`define CSR_LEN_PRESENCE 4'h4
`define CSR_LEN_SPACE 4'h6
`define CSR_LEN_VERSION 4'h1
`define CSR_LEN_ERR_FLAGS 4'h1
`define CSR_LEN_ERR_LOG 4'hA
`define CSR_ERR_DEPTH 5
`define CSR_FW_VERSION 16'h0064
`define CSR_KB_SHIFT 10
`endif

// file: pkg/csr_pkg.sv
// types shared by the card status reader
package csr_pkg;
  typedef enum logic [1:0] {CSR_IDLE, CSR_SEND, CSR_FINISH} csr_state_e;
  typedef enum logic [2:0] {
    CSR_K_NONE, CSR_K_FILE, CSR_K_PRES, CSR_K_SPACE, CSR_K_VER, CSR_K_FLAGS, CSR_K_LOG
  } csr_kind_e;
endpackage

// file: test/csr_host_model.sv
// host side of the query port: issues one status query at a time
`timescale 1ns/1ns
`default_nettype none
module csr_host_model (
  input wire logic sys_clk,
  input wire logic reqReady,
  input wire logic reqDone,
  input wire logic reqInvalid,
  output logic reqValid,
  output logic [15:0] reqSelector,
  output logic [15:0] reqChannel
);
  initial begin
    reqValid = 1'b0;
    reqSelector = 16'h0000;
    reqChannel = 16'h0001;
  end
  // only status queries travel on this port
  task automatic query(input logic [15:0] s, input logic [15:0] c, output int ok);
    int n;
    n = 0;
    ok = 0;
    reqSelector <= s;
    reqChannel <= c;
    reqValid <= 1'b1;
    // the request stands until an edge that sees the responder ready
    do begin
      @(posedge sys_clk);
      n++;
    end while (reqReady !== 1'b1 && n < 16);
    reqValid <= 1'b0;
    // selector and channel stay put until done or refusal
    while (ok == 0 && n < 32) begin
      @(posedge sys_clk);
      n++;
      if (reqDone === 1'b1 || reqInvalid === 1'b1) begin
        ok = 1;
      end
    end
  endtask
endmodule
`default_nettype wire

// file: test/csr_status_reader_assertions.sv
// port-level checks of the card status reader
`timescale 1ns/1ns
`default_nettype none
module csr_status_reader_assertions
  import csr_pkg::*;
#(
  parameter int FILES = 64,
  parameter logic [15:0] FW_VERSION = 16'h0064
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic [15:0] reqSelector,
  input wire logic [15:0] reqChannel,
  input wire logic wordValid,
  input wire logic [3:0] wordIndex,
  input wire logic [15:0] wordData,
  input wire logic reqDone,
  input wire logic reqInvalid,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdData,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire logic acc = reqValid && reqReady;
  wire logic chOk = reqChannel == 16'h0001 || reqChannel == 16'h0002;
  wire logic go = acc && chOk;
  property p_file;
    // words show from the second edge after the request is taken
    go && reqSelector <= 16'h003F |=> ##1 wordValid && wordIndex == 4'h0
      ##1 wordValid && wordIndex == 4'h1 ##1 reqDone;
  endproperty
  a_file: assert property (p_file) else $error("file query shape wrong");
  property p_line;
    go && reqSelector <= 16'h003F |=> ##1 wordValid && wordData != 16'h0000;
  endproperty
  a_line: assert property (p_line) else $error("last line below one");
  property p_pres;
    go && reqSelector == 16'h0100 |=> ##1 wordValid [*4] ##1 reqDone && !wordValid;
  endproperty
  a_pres: assert property (p_pres) else $error("presence map length wrong");
  property p_space;
    go && reqSelector == 16'h0200 |=> ##1 wordValid [*6] ##1 reqDone && !wordValid;
  endproperty
  a_space: assert property (p_space) else $error("space block length wrong");
  property p_ver;
    go && reqSelector == 16'h0300 |=> ##1 wordValid && wordData == FW_VERSION ##1 reqDone;
  endproperty
  a_ver: assert property (p_ver) else $error("version word wrong");
  property p_flags;
    go && reqSelector == 16'h0400 |=> ##1 wordValid && wordData[15:5] == 11'h000 ##1 reqDone;
  endproperty
  a_flags: assert property (p_flags) else $error("unused flag bits set");
  property p_log;
    go && reqSelector == 16'h0500 |=> ##1 wordValid && wordIndex == 4'h0
      ##9 wordValid && wordIndex == 4'h9 ##1 reqDone;
  endproperty
  a_log: assert property (p_log) else $error("error log length wrong");
  property p_inv;
    acc && (reqSelector > 16'h0500 || !chOk) |=> reqInvalid && !wordValid ##1 !reqDone;
  endproperty
  a_inv: assert property (p_inv) else $error("bad query not refused");
  property p_busy;
    wordValid |-> !reqReady && !reqInvalid;
  endproperty
  a_busy: assert property (p_busy) else $error("ready during reply");
endmodule
bind csr_status_reader csr_status_reader_assertions #(.FILES(FILES), .FW_VERSION(FW_VERSION)) u_chk (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .reqValid(reqValid),
  .reqReady(reqReady),
  .reqSelector(reqSelector),
  .reqChannel(reqChannel),
  .wordValid(wordValid),
  .wordIndex(wordIndex),
  .wordData(wordData),
  .reqDone(reqDone),
  .reqInvalid(reqInvalid),
  .regAddr(regAddr),
  .regWrData(regWrData),
  .regWr(regWr),
  .regRd(regRd),
  .regRdData(regRdData),
  .irq(irq)
);
`default_nettype wire

// file: test/csr_status_reader_tb_top.sv
// self-checking bench for the card status reader
`timescale 1ns/1ns
`default_nettype none
module csr_status_reader_tb_top;
  import csr_pkg::*;
  logic sys_clk = 0;
  logic sys_rst = 1;
  logic regWr = 0;
  logic regRd = 0;
  logic [7:0] regAddr = 0;
  logic [31:0] regWrData = 0;
  logic reqValid, reqReady, wordValid, reqDone, reqInvalid, irq;
  logic [15:0] reqSelector, reqChannel, wordData;
  logic [3:0] wordIndex;
  logic [31:0] regRdData;
  logic [2:0] ctl = 0;
  int n_mismatch = 0, check_count = 0, nDone = 0, nInv = 0, okQ, lin, col, mx;
  int sels[8] = '{5, 63, 256, 512, 768, 1024, 64, 1281};
  logic [15:0] got[$], exp[$];
  logic [31:0] lg[$], t;
  logic [63:0] pres;
  int unsigned cap, used, fre;
  always #25 sys_clk = ~sys_clk;
  csr_status_reader u_csr_status_reader (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .reqValid(reqValid),
    .reqReady(reqReady),
    .reqSelector(reqSelector),
    .reqChannel(reqChannel),
    .wordValid(wordValid),
    .wordIndex(wordIndex),
    .wordData(wordData),
    .reqDone(reqDone),
    .reqInvalid(reqInvalid),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWr(regWr),
    .regRd(regRd),
    .regRdData(regRdData),
    .irq(irq)
  );
  csr_host_model u_csr_host_model (
    .sys_clk(sys_clk),
    .reqReady(reqReady),
    .reqDone(reqDone),
    .reqInvalid(reqInvalid),
    .reqValid(reqValid),
    .reqSelector(reqSelector),
    .reqChannel(reqChannel)
  );
  // outputs are collected at the falling edge, where they have settled
  always @(negedge sys_clk) begin
    if (wordValid === 1'b1) got.push_back(wordData);
    if (reqDone === 1'b1) nDone++;
    if (reqInvalid === 1'b1) nInv++;
  end
  task chk(string n, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(logic [7:0] a, logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1;
    @(posedge sys_clk);
    regWr <= 0;
    @(posedge sys_clk);
  endtask
  task rd(logic [7:0] a, logic [31:0] e);
    regAddr <= a;
    regRd <= 1;
    @(posedge sys_clk);
    regRd <= 0;
    @(negedge sys_clk);
    chk("regRdData", e, regRdData);
    @(posedge sys_clk);
  endtask
  task ci(logic e);
    @(negedge sys_clk);
    chk("irq", 32'(e), 32'(irq));
    @(posedge sys_clk);
  endtask
  function int unsigned kb(int unsigned x);
    return x == 0 ? 0 : (x < 1024 ? 1 : x >> 10);
  endfunction
  task mk(int s, int c);
    int unsigned l, m, v[3];
    exp = {};
    if (c < 1 || c > 2) return;
    if (s < 64) begin
      l = s == 5 ? lin : 0;
      m = s == 5 ? mx : 0;
      if (m == 0) m = 1;
      if (l == 0) l = 1;
      exp = {16'(l > m ? m : l), 16'(s == 5 ? col : 0)};
    end else if (s == 256) for (int w = 0; w < 4; w++) exp.push_back(pres[16*w+:16]);
    else if (s == 512) begin
      v = '{kb(cap), kb(used), kb(fre)};
      foreach (v[i]) begin
        exp.push_back(v[i][15:0]);
        exp.push_back(v[i][31:16]);
      end
    end else if (s == 768) exp = {16'h0064};
    else if (s == 1024) exp = {{11'h000, ctl[2:1], lg.size() != 0, ctl[0] && kb(fre) == 0, !ctl[0]}};
    else if (s == 1280) for (int k = 0; k < 5; k++) begin
      v[0] = k < lg.size() ? lg[k] : 0;
      exp.push_back(v[0][15:0]);
      exp.push_back(v[0][31:16]);
    end
  endtask
  task q(int s, int c);
    int d0, i0;
    d0 = nDone;
    i0 = nInv;
    mk(s, c);
    got = {};
    u_csr_host_model.query(16'(s), 16'(c), okQ);
    chk("finished", 1, okQ);
    chk("word count", exp.size(), got.size());
    foreach (exp[i]) chk("word", exp[i], got[i]);
    chk("done", exp.size() != 0, nDone - d0);
    chk("invalid", exp.size() == 0, nInv - i0);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    print_verdict;
  end
  initial begin
    void'($urandom(49391));
    repeat (3) @(posedge sys_clk);
    sys_rst <= 0;
    @(posedge sys_clk);
    ci(0);
    q(1024, 1);
    for (int i = 7; i > 0; i -= 2) begin
      ctl = 3'(i);
      wr(8'h00, 32'(ctl));
      q(1024, 2);
    end
    pres = {$urandom, $urandom};
    cap = $urandom;
    used = $urandom;
    fre = $urandom % 1000 + 1;
    lin = 30;
    mx = 10;
    col = $urandom % 65536;
    wr(8'h10, pres[31:0]);
    wr(8'h14, pres[63:32]);
    wr(8'h18, cap);
    wr(8'h1C, used);
    wr(8'h20, fre);
    wr(8'h04, 32'h0000_0005);
    wr(8'h0C, mx);
    wr(8'h08, {col[15:0], lin[15:0]});
    wr(8'h34, 32'h0000_0001);
    for (int e = 0; e < 7; e++) begin
      t = $urandom;
      lg.push_front(t);
      if (lg.size() > 5) void'(lg.pop_back());
      wr(8'h24, t);
      q(1280, 1);
    end
    rd(8'h2C, 32'h0000_0005);
    for (int c = 1; c < 4; c++) foreach (sels[i]) q(sels[i], c);
    fre = 0;
    wr(8'h20, 0);
    q(1024, 1);
    q(512, 2);
    ci(1);
    wr(8'h38, 32'h0000_0007);
    ci(0);
    rd(8'h30, 32'h0000_0000);
    wr(8'h34, 32'h0000_0002);
    q(768, 1);
    ci(0);
    q(768, 3);
    ci(1);
    rd(8'h30, 32'h0000_0003);
    rd(8'hFC, 32'h0000_0000);
    wr(8'h28, 32'h0000_0001);
    lg = {};
    q(1280, 2);
    rd(8'h2C, 32'h0000_0000);
    print_verdict;
  end
endmodule
`default_nettype wire
